// ---- rtl/sbt_pkg.sv ----
package sbt_pkg;

	// ==========================================
	// Register map
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_FORCE = 8'h04;
	localparam logic [7:0] OFS_COUNT = 8'h08;
	localparam logic [7:0] OFS_CMPA = 8'h0c;
	localparam logic [7:0] OFS_CMPB = 8'h10;
	localparam logic [7:0] OFS_CAPTOP = 8'h14;
	localparam logic [7:0] OFS_FLAGS = 8'h18;
	localparam int CTRL_W = 13;

	// Flag bit positions
	localparam int FLG_OVF = 0;
	localparam int FLG_CMPA = 1;
	localparam int FLG_CMPB = 2;
	localparam int FLG_CAP = 3;
	localparam int FLG_W = 4;

	// ==========================================
	// Counter values
	localparam logic [15:0] CNT_BOTTOM = 16'h0000;
	localparam logic [15:0] CNT_MAX = 16'hffff;
	localparam logic [15:0] TOP_8BIT = 16'h00ff;
	localparam logic [15:0] TOP_9BIT = 16'h01ff;
	localparam logic [15:0] TOP_10BIT = 16'h03ff;

	// ==========================================
	// Waveform mode values
	localparam logic [3:0] WM_PC8 = 4'h1;
	localparam logic [3:0] WM_PC9 = 4'h2;
	localparam logic [3:0] WM_PC10 = 4'h3;
	localparam logic [3:0] WM_CTC_A = 4'h4;
	localparam logic [3:0] WM_FAST8 = 4'h5;
	localparam logic [3:0] WM_FAST9 = 4'h6;
	localparam logic [3:0] WM_FAST10 = 4'h7;
	localparam logic [3:0] WM_PFC_ICR = 4'h8;
	localparam logic [3:0] WM_PFC_A = 4'h9;
	localparam logic [3:0] WM_PC_ICR = 4'ha;
	localparam logic [3:0] WM_PC_A = 4'hb;
	localparam logic [3:0] WM_CTC_ICR = 4'hc;
	localparam logic [3:0] WM_FAST_ICR = 4'he;
	localparam logic [3:0] WM_FAST_A = 4'hf;

	// Compare output mode values
	localparam logic [1:0] COM_OFF = 2'h0;
	localparam logic [1:0] COM_TOGGLE = 2'h1;
	localparam logic [1:0] COM_NONINV = 2'h2;
	localparam logic [1:0] COM_INV = 2'h3;

	// ==========================================
	// Prescaler selections and masks
	localparam logic [2:0] PRE_STOP = 3'h0;
	localparam logic [2:0] PRE_DIV1 = 3'h1;
	localparam logic [2:0] PRE_DIV8 = 3'h2;
	localparam logic [2:0] PRE_DIV64 = 3'h3;
	localparam logic [2:0] PRE_DIV256 = 3'h4;
	localparam logic [2:0] PRE_DIV1024 = 3'h5;
	localparam logic [9:0] MSK_DIV1 = 10'h000;
	localparam logic [9:0] MSK_DIV8 = 10'h007;
	localparam logic [9:0] MSK_DIV64 = 10'h03f;
	localparam logic [9:0] MSK_DIV256 = 10'h0ff;
	localparam logic [9:0] MSK_DIV1024 = 10'h3ff;

	// ==========================================
	// Types
	typedef struct packed {
		logic [1:0] pin_dir;
		logic [2:0] clk_sel;
		logic [1:0] com_b;
		logic [1:0] channel_a_output_mode;
		logic [3:0] waveform_mode_field;
	} sbt_ctrl_t;

	typedef enum logic {
		DIR_UP = 1'b0,
		DIR_DOWN = 1'b1
	} sbt_dir_t;

endpackage : sbt_pkg

// ---- rtl/sbt_prescaler.sv ----
`timescale 1ns/1ps
module sbt_prescaler
	import sbt_pkg::*;
(
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic [2:0] sel_i,
	output logic tick_o
);
	logic [9:0] pre_reg;
	logic [9:0] mask;

	always_comb begin
		case (sel_i)
			PRE_DIV8: mask = MSK_DIV8;
			PRE_DIV64: mask = MSK_DIV64;
			PRE_DIV256: mask = MSK_DIV256;
			PRE_DIV1024: mask = MSK_DIV1024;
			default: mask = MSK_DIV1;
		endcase
	end

	// Stopped prescaler restarts from zero for a full first period
	always_ff @(posedge clk_i) begin
		if (reset_i || sel_i == PRE_STOP) begin
			pre_reg <= 10'h000;
		end else begin
			pre_reg <= pre_reg + 10'h001;
		end
	end

	// One tick every N clocks
	assign tick_o = (sel_i != PRE_STOP) && ((pre_reg & mask) == mask);
endmodule : sbt_prescaler

// ---- rtl/sbt_timer.sv ----
// Chosen here: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module sbt_timer
	import sbt_pkg::*;
(
	input wire logic CLK_I,
	input wire logic RESET_I,
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [7:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	output logic [31:0] PRDATA_O,
	output logic PREADY_O,
	output logic PSLVERR_O,
	output logic WAVE_A_O,
	output logic WAVE_A_OE_O,
	output logic WAVE_B_O,
	output logic WAVE_B_OE_O
);
	// ==========================================
	// Mode decoding
	function automatic logic is_fast(input logic [3:0] m);
		return m == WM_FAST8 || m == WM_FAST9 || m == WM_FAST10 ||
			m == WM_FAST_ICR || m == WM_FAST_A;
	endfunction : is_fast

	function automatic logic is_dual(input logic [3:0] m);
		return m == WM_PC8 || m == WM_PC9 || m == WM_PC10 || m == WM_PC_ICR ||
			m == WM_PC_A || m == WM_PFC_ICR || m == WM_PFC_A;
	endfunction : is_dual

	function automatic logic is_ctc(input logic [3:0] m);
		return m == WM_CTC_A || m == WM_CTC_ICR;
	endfunction : is_ctc

	function automatic logic top_by_a(input logic [3:0] m);
		return m == WM_CTC_A || m == WM_FAST_A || m == WM_PC_A || m == WM_PFC_A;
	endfunction : top_by_a

	function automatic logic top_by_icr(input logic [3:0] m);
		return m == WM_CTC_ICR || m == WM_FAST_ICR || m == WM_PC_ICR || m == WM_PFC_ICR;
	endfunction : top_by_icr

	// All ones when no fixed top is selected
	function automatic logic [15:0] fixed_mask(input logic [3:0] m);
		case (m)
			WM_PC8, WM_FAST8: return TOP_8BIT;
			WM_PC9, WM_FAST9: return TOP_9BIT;
			WM_PC10, WM_FAST10: return TOP_10BIT;
			default: return CNT_MAX;
		endcase
	endfunction : fixed_mask

	function automatic logic is_mapped(input logic [7:0] a);
		return a == OFS_CTRL || a == OFS_FORCE || a == OFS_COUNT || a == OFS_CMPA ||
			a == OFS_CMPB || a == OFS_CAPTOP || a == OFS_FLAGS;
	endfunction : is_mapped

	// ==========================================
	// State
	sbt_ctrl_t ctrl_reg;
	sbt_dir_t dir_reg;
	logic [15:0] cnt_reg;
	logic [15:0] captop_reg;
	logic [15:0] cmp_buf_reg [0:1];
	logic [15:0] cmp_act_reg [0:1];
	logic [FLG_W-1:0] flags_reg;
	logic [FLG_W-1:0] flags_set;
	logic [31:0] prdata_reg;
	logic pready_reg;
	logic pslverr_reg;
	logic [1:0] wave;
	logic [1:0] pin_reg;
	logic [1:0] oe_reg;
	logic [1:0] match;
	logic [1:0] frc;
	logic [1:0] com [0:1];
	logic [3:0] mode;
	logic [15:0] top;
	logic tick;
	logic fast;
	logic dual;
	logic pwm;
	logic at_top;
	logic wr_en;
	logic acc_start;

	assign mode = ctrl_reg.waveform_mode_field;
	assign fast = is_fast(mode);
	assign dual = is_dual(mode);
	assign pwm = fast || dual;
	assign com[0] = ctrl_reg.channel_a_output_mode;
	assign com[1] = ctrl_reg.com_b;

	assign top = top_by_a(mode) ? cmp_act_reg[0] :
		top_by_icr(mode) ? captop_reg : fixed_mask(mode);
	assign at_top = cnt_reg == top;

	// ==========================================
	// Prescaler
	sbt_prescaler u_pre (
		.clk_i(CLK_I),
		.reset_i(RESET_I),
		.sel_i(ctrl_reg.clk_sel),
		.tick_o(tick)
	);

	// ==========================================
	// APB slave: three-cycle access (one wait state), write lands at the completing edge
	assign acc_start = PSEL_I && PENABLE_I && !pready_reg;
	assign wr_en = PSEL_I && PENABLE_I && PWRITE_I && pready_reg;
	assign frc = (wr_en && PADDR_I == OFS_FORCE) ? PWDATA_I[1:0] : 2'h0;

	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= 32'h0000_0000;
		end else begin
			pready_reg <= acc_start;
			pslverr_reg <= acc_start && !is_mapped(PADDR_I);
			if (acc_start && !PWRITE_I) begin
				case (PADDR_I)
					OFS_CTRL: prdata_reg <= 32'(ctrl_reg);
					OFS_COUNT: prdata_reg <= 32'(cnt_reg);
					OFS_CMPA: prdata_reg <= 32'(cmp_buf_reg[0]);
					OFS_CMPB: prdata_reg <= 32'(cmp_buf_reg[1]);
					OFS_CAPTOP: prdata_reg <= 32'(captop_reg);
					OFS_FLAGS: prdata_reg <= 32'({dir_reg, wave, flags_reg});
					default: prdata_reg <= 32'h0000_0000;
				endcase
			end
		end
	end

	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			ctrl_reg <= '0;
		end else if (wr_en && PADDR_I == OFS_CTRL) begin
			ctrl_reg <= sbt_ctrl_t'(PWDATA_I[CTRL_W-1:0]);
		end
	end

	// No buffer: a value under the count is missed until wrap
	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			captop_reg <= CNT_BOTTOM;
		end else if (wr_en && PADDR_I == OFS_CAPTOP) begin
			captop_reg <= PWDATA_I[15:0];
		end
	end

	// ==========================================
	// Counter
	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			cnt_reg <= CNT_BOTTOM;
			dir_reg <= DIR_UP;
		end else if (wr_en && PADDR_I == OFS_COUNT) begin
			cnt_reg <= PWDATA_I[15:0];
		end else if (!dual) begin
			dir_reg <= DIR_UP;
			if (tick) begin
				if ((fast || is_ctc(mode)) && at_top) begin
					cnt_reg <= CNT_BOTTOM;
				end else begin
					cnt_reg <= cnt_reg + 16'h0001;
				end
			end
		end else if (tick) begin
			case (dir_reg)
				DIR_UP: begin
					if (at_top) begin
						dir_reg <= DIR_DOWN;
						cnt_reg <= cnt_reg - 16'h0001;
					end else begin
						cnt_reg <= cnt_reg + 16'h0001;
					end
				end
				DIR_DOWN: begin
					if (cnt_reg == CNT_BOTTOM) begin
						dir_reg <= DIR_UP;
						cnt_reg <= cnt_reg + 16'h0001;
					end else begin
						cnt_reg <= cnt_reg - 16'h0001;
					end
				end
				default: dir_reg <= DIR_UP;
			endcase
		end
	end

	// ==========================================
	// Flags: hardware set wins over a write-one clear
	always_comb begin
		flags_set = '0;
		if (tick) begin
			if (dual) begin
				flags_set[FLG_OVF] = dir_reg == DIR_DOWN && cnt_reg == CNT_BOTTOM;
			end else if (fast) begin
				flags_set[FLG_OVF] = at_top;
			end else begin
				flags_set[FLG_OVF] = cnt_reg == CNT_MAX;
			end
			flags_set[FLG_CAP] = at_top && top_by_icr(mode) && (dual ? dir_reg == DIR_UP : 1'b1);
			flags_set[FLG_CMPA] = match[0] || (at_top && top_by_a(mode) && !dual);
		end
		flags_set[FLG_CMPB] = match[1];
	end

	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			flags_reg <= '0;
		end else begin
			if (wr_en && PADDR_I == OFS_FLAGS) begin
				flags_reg <= (flags_reg & ~PWDATA_I[FLG_W-1:0]) | flags_set;
			end else begin
				flags_reg <= flags_reg | flags_set;
			end
		end
	end

	// ==========================================
	// Compare channels
	for (genvar i = 0; i < 2; i++) begin : g_ch
		logic w_reg;
		logic tog_ok;

		assign match[i] = tick && cnt_reg == cmp_act_reg[i];
		assign tog_ok = i == 0 && (mode == WM_FAST_A || mode == WM_PC_A || mode == WM_PFC_A);
		assign wave[i] = w_reg;

		// Buffered in PWM modes so the period never tears mid-cycle
		always_ff @(posedge CLK_I) begin
			if (RESET_I) begin
				cmp_buf_reg[i] <= CNT_BOTTOM;
				cmp_act_reg[i] <= CNT_BOTTOM;
			end else begin
				if (wr_en && PADDR_I == (i == 0 ? OFS_CMPA : OFS_CMPB)) begin
					cmp_buf_reg[i] <= PWDATA_I[15:0] & fixed_mask(mode);
				end
				if (!pwm) begin
					cmp_act_reg[i] <= cmp_buf_reg[i];
				end else if (tick && at_top && (fast || dir_reg == DIR_UP)) begin
					cmp_act_reg[i] <= cmp_buf_reg[i];
				end
			end
		end

		// Output mode is read at the match itself, so changes act there
		always_ff @(posedge CLK_I) begin
			if (RESET_I) begin
				w_reg <= 1'b0;
			end else if (!pwm && (frc[i] || match[i])) begin
				case (com[i])
					COM_TOGGLE: w_reg <= ~w_reg;
					COM_NONINV: w_reg <= 1'b0;
					COM_INV: w_reg <= 1'b1;
					default: w_reg <= w_reg;
				endcase
			end else if (fast && tick && at_top && com[i] >= COM_NONINV) begin
				w_reg <= com[i] == COM_INV;
			end else if (fast && match[i]) begin
				case (com[i])
					COM_TOGGLE: w_reg <= tog_ok ? ~w_reg : w_reg;
					COM_NONINV: w_reg <= 1'b1;
					COM_INV: w_reg <= 1'b0;
					default: w_reg <= w_reg;
				endcase
			end else if (dual && match[i]) begin
				case (com[i])
					COM_TOGGLE: w_reg <= tog_ok ? ~w_reg : w_reg;
					COM_NONINV: w_reg <= dir_reg == DIR_DOWN;
					COM_INV: w_reg <= dir_reg == DIR_UP;
					default: w_reg <= w_reg;
				endcase
			end
		end

		always_ff @(posedge CLK_I) begin
			if (RESET_I) begin
				pin_reg[i] <= 1'b0;
				oe_reg[i] <= 1'b0;
			end else begin
				pin_reg[i] <= w_reg && ctrl_reg.pin_dir[i];
				oe_reg[i] <= ctrl_reg.pin_dir[i];
			end
		end
	end

	assign PRDATA_O = prdata_reg;
	assign PREADY_O = pready_reg;
	assign PSLVERR_O = pslverr_reg;
	assign WAVE_A_O = pin_reg[0];
	assign WAVE_B_O = pin_reg[1];
	assign WAVE_A_OE_O = oe_reg[0];
	assign WAVE_B_OE_O = oe_reg[1];

	// ==========================================
	// Checks
	fast_ovf_a: assert property (@(posedge CLK_I) disable iff (RESET_I)
		tick && fast && at_top |=> flags_reg[FLG_OVF] && (flags_reg[FLG_CMPA] || !top_by_a($past(mode))))
		else $error("fast overflow flag missed");

	fast_clear_a: assert property (@(posedge CLK_I) disable iff (RESET_I)
		tick && fast && at_top && !wr_en |=> cnt_reg == CNT_BOTTOM)
		else $error("fast counter not cleared after top");

	buf_load_a: assert property (@(posedge CLK_I) disable iff (RESET_I)
		tick && fast && at_top |=> cmp_act_reg[0] == $past(cmp_buf_reg[0]))
		else $error("compare A buffer not loaded at top");

	cmpb_flag_a: assert property (@(posedge CLK_I) disable iff (RESET_I)
		tick && cnt_reg == cmp_act_reg[1] |=> flags_reg[FLG_CMPB])
		else $error("compare B flag missed");

	ctc_toggle_a: assert property (@(posedge CLK_I) disable iff (RESET_I)
		is_ctc(mode) && match[0] && com[0] == COM_TOGGLE |=> wave[0] != $past(wave[0]))
		else $error("wave A did not toggle");

	pin_gate_a: assert property (@(posedge CLK_I) disable iff (RESET_I)
		!ctrl_reg.pin_dir[0] |=> !WAVE_A_O && !WAVE_A_OE_O)
		else $error("wave A driven while pin is input");

	tick_idle_a: assert property (@(posedge CLK_I) disable iff (RESET_I)
		!tick && !(wr_en && PADDR_I == OFS_COUNT) |=> cnt_reg == $past(cnt_reg))
		else $error("counter moved without a tick");

	pc_turn_a: assert property (@(posedge CLK_I) disable iff (RESET_I)
		tick && dual && dir_reg == DIR_UP && at_top && !wr_en
		|=> dir_reg == DIR_DOWN && cnt_reg == $past(cnt_reg) - 16'h0001)
		else $error("phase correct did not turn at top");

	ctc_ovf_a: assert property (@(posedge CLK_I) disable iff (RESET_I)
		tick && is_ctc(mode) && cnt_reg == CNT_MAX |=> flags_reg[FLG_OVF])
		else $error("overflow flag missed at wrap");

	cmp_mask_a: assert property (@(posedge CLK_I) disable iff (RESET_I)
		wr_en && PADDR_I == OFS_CMPA |=> (cmp_buf_reg[0] & ~fixed_mask($past(mode))) == 16'h0000)
		else $error("compare write not masked");
endmodule : sbt_timer

// ---- rtl/_unused.sv ----
`timescale 1ns/1ps

// ---- testbench/sbt_load_model.sv ----
`timescale 1ns/1ps
// ==========================================
// Load on one waveform pin
module sbt_load_model (
	input wire logic wave_i,
	input wire logic oe_i,
	output logic pin_o
);
	// Pull-down holds the pin low while the timer leaves it floating
	assign pin_o = oe_i ? wave_i : 1'b0;
endmodule : sbt_load_model

// ---- testbench/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
	import sbt_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic pen = 1'b0;
	logic pwr = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, q;
	logic pready, pslverr, e, lv, wa, wa_oe, wb, wb_oe, pin_a, pin_b;
	int miscompares = 0;
	int checks = 0;
	int hi, per, h1, h2, c1, c2, n;
	int dv [0:5] = '{0, 1, 8, 64, 256, 1024};

	always #5 clk = ~clk;

	sbt_timer dut_u (.CLK_I(clk), .RESET_I(rst), .PSEL_I(psel), .PENABLE_I(pen),
		.PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
		.PREADY_O(pready), .PSLVERR_O(pslverr), .WAVE_A_O(wa), .WAVE_A_OE_O(wa_oe),
		.WAVE_B_O(wb), .WAVE_B_OE_O(wb_oe));
	sbt_load_model load_a (.wave_i(wa), .oe_i(wa_oe), .pin_o(pin_a));
	sbt_load_model load_b (.wave_i(wb), .oe_i(wb_oe), .pin_o(pin_b));

	// ==========================================
	// Checking and reporting
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string s);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: %s got %h exp %h", $time, s, got, exp);
		end
	endtask : chk

	task automatic conclude;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : conclude

	function automatic logic [31:0] ctrl(logic [3:0] wm, logic [1:0] ca, logic [1:0] cb,
		logic [2:0] cs, logic [1:0] dir);
		return {19'h0, dir, cs, cb, ca, wm};
	endfunction : ctrl

	function automatic int ctc_period(int cs, int cmp);
		return 2 * dv[cs] * (1 + cmp);
	endfunction : ctc_period

	function automatic logic pin(logic b);
		return b ? pin_b : pin_a;
	endfunction : pin

	// ==========================================
	// APB master
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clk);
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
		if (k >= 20) chk(32'h0, 32'h1, "apb hang");
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task automatic rd(input logic [7:0] a);
		apb(1'b0, a, 32'h0);
	endtask : rd

	// Stopped while reprogramming, so the count never runs past a new top unless it is a buffered compare A top
	task automatic setup(logic [3:0] wm, logic [1:0] ca, logic [1:0] cb, logic [2:0] cs,
		logic [15:0] va, logic [15:0] vb, logic [15:0] cap);
		wr(OFS_CTRL, ctrl(wm, ca, cb, PRE_STOP, 2'h3));
		wr(OFS_COUNT, 32'h0);
		wr(OFS_CMPA, {16'h0, va});
		wr(OFS_CMPB, {16'h0, vb});
		wr(OFS_CAPTOP, {16'h0, cap});
		wr(OFS_FLAGS, 32'hf);
		wr(OFS_CTRL, ctrl(wm, ca, cb, cs, 2'h3));
	endtask : setup

	// ==========================================
	// Pin waveform measurement in clocks
	task automatic hold(input logic b, input logic lvl, inout int k);
		while (pin(b) === lvl && k < 30000) begin
			@(posedge clk);
			k++;
		end
	endtask : hold

	task automatic measure(input logic b);
		int k, s;
		k = 0;
		// First period after a restart may be irregular, so skip it
		hold(b, 1'b1, k);
		hold(b, 1'b0, k);
		hold(b, 1'b1, k);
		hold(b, 1'b0, k);
		s = k;
		hold(b, 1'b1, k);
		hi = k - s;
		hold(b, 1'b0, k);
		per = k - s;
		if (k >= 30000) chk(32'h0, 32'h1, "wave stuck");
	endtask : measure

	initial begin
		#(800_000);
		miscompares++;
		conclude();
	end

	// ==========================================
	// Tests
	initial begin
		void'($urandom(17));
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		rd(OFS_CTRL);
		chk(q, 32'h0, "ctrl reset");
		rd(OFS_FLAGS);
		chk(q, 32'h0, "flags reset");
		rd(8'h1c);
		chk({31'h0, e}, 32'h1, "unmapped error");
		chk(q, 32'h0, "unmapped data");
		$display("test reset done");

		setup(WM_CTC_A, COM_TOGGLE, COM_OFF, PRE_STOP, 16'h0, 16'h0, 16'h0);
		wr(OFS_CTRL, ctrl(WM_CTC_A, COM_TOGGLE, COM_OFF, PRE_STOP, 2'h0));
		rd(OFS_FLAGS);
		lv = q[4];
		wr(OFS_FORCE, 32'h1);
		rd(OFS_FLAGS);
		chk(32'(q[5:0]), 32'({1'b0, ~lv, 4'h0}), "force toggle");
		chk(32'({wa, wa_oe}), 32'h0, "pin gated");
		wr(OFS_CTRL, ctrl(WM_CTC_A, COM_TOGGLE, COM_OFF, PRE_STOP, 2'h1));
		repeat (3) @(posedge clk);
		chk(32'({pin_a, wa_oe, wb_oe}), 32'({~lv, 1'b1, 1'b0}), "pin driven");
		$display("test force done");

		for (n = 1; n <= 5; n++) begin
			c1 = $urandom_range(0, 2);
			setup(WM_CTC_A, COM_TOGGLE, COM_OFF, n[2:0], c1[15:0], 16'h0, 16'h0);
			measure(1'b0);
			chk(per, ctc_period(n, c1), "toggle period");
		end
		$display("test prescaler done");

		setup(WM_CTC_A, COM_OFF, COM_OFF, PRE_STOP, 16'h5, 16'h0, 16'h0);
		wr(OFS_COUNT, 32'hfff0);
		wr(OFS_CTRL, ctrl(WM_CTC_A, COM_OFF, COM_OFF, PRE_DIV1, 2'h3));
		rd(OFS_FLAGS);
		chk(32'(q[3:0]), 32'h0, "no early flags");
		repeat (40) @(posedge clk);
		rd(OFS_FLAGS);
		chk(32'(q[3:0]), 32'h7, "wrap flags");
		rd(OFS_COUNT);
		chk(32'(q[15:0] <= 16'h5), 32'h1, "count below top");
		$display("test wrap done");

		setup(WM_FAST8, COM_NONINV, COM_OFF, PRE_STOP, 16'h1234, 16'h0, 16'h0);
		rd(OFS_CMPA);
		chk(q, 32'h34, "compare masked");
		c1 = $urandom_range(16, 96);
		c2 = c1 + $urandom_range(16, 64);
		setup(WM_FAST8, COM_NONINV, COM_OFF, PRE_DIV1, c1[15:0], 16'h0, 16'h0);
		measure(1'b0);
		h1 = hi;
		chk(per, 256, "fast period");
		rd(OFS_FLAGS);
		chk(32'(q[3:0]), 32'h7, "fast flags");
		setup(WM_FAST8, COM_NONINV, COM_OFF, PRE_DIV1, c2[15:0], 16'h0, 16'h0);
		measure(1'b0);
		h2 = hi;
		chk(h1 - h2, c2 - c1, "duty follows compare");
		setup(WM_FAST8, COM_INV, COM_OFF, PRE_DIV1, c1[15:0], 16'h0, 16'h0);
		measure(1'b0);
		chk(h1 + hi, 256, "inverted duty");
		setup(WM_FAST8, COM_NONINV, COM_OFF, PRE_DIV1, 16'h0, 16'h0, 16'h0);
		measure(1'b0);
		chk(per - hi, 1, "bottom spike");
		setup(WM_FAST8, COM_NONINV, COM_INV, PRE_DIV1, 16'hff, 16'hff, 16'h0);
		repeat (300) @(posedge clk);
		n = 0;
		repeat (600) begin
			@(posedge clk);
			if (pin_a !== 1'b0 || pin_b !== 1'b1) n++;
		end
		chk(n, 0, "constant level");
		$display("test fast done");

		setup(WM_FAST_A, COM_TOGGLE, COM_OFF, PRE_DIV1, 16'h3, 16'h0, 16'h0);
		measure(1'b0);
		chk(per, 8, "mode 15 toggle");
		wr(OFS_CMPA, 32'h7);
		measure(1'b0);
		chk(per, 16, "buffered top");
		$display("test toggle done");

		// Software keeps both compares at or below top
		setup(WM_FAST_ICR, COM_NONINV, COM_NONINV, PRE_DIV1, 16'h10, 16'h8, 16'h20);
		measure(1'b1);
		chk(per, 33, "capture top");
		rd(OFS_FLAGS);
		chk(32'(q[3:0]), 32'hf, "capture flags");
		$display("test capture done");

		setup(WM_PC8, COM_NONINV, COM_OFF, PRE_DIV1, 16'h20, 16'h0, 16'h0);
		measure(1'b0);
		chk(per, 510, "dual slope period");
		chk(32'(hi < 255), 32'h1, "dual slope polarity");
		$display("test phase done");
		conclude();
	end
endmodule : tb_top
